// [rtl/tlp_test_unit.sv]
// t1 test function block: prbs, loopbacks, alarm simulation, defect insertion
`timescale 1ns/1ps
// How it works
// - two prbs lengths, at most 14 zeros when not inverted
// - pattern sent to line, optionally inverted
// - monitor locks true or inverted, reports lock
// - each mismatch while locked counts when counting enabled
// - lock within 400 ms at 1e-1
// - framed skips framing bits, unframed uses all
// - remote loop returns line data, still received
// - remote loop through or around jitter buffer
// - payload loop returns 192 payload bits
// - transparent bit picks own or received framing
// - payload loop ignores system input, optional ais
// - local loop feeds system data to receiver
// - line ais does not touch remote or local looped data
// - one selected slot of 24 looped
// - idle code sent in looped slot
// - simulation hides real alarms, traffic untouched
// - simulation covers alarms, slips and counters
// - each trigger advances step, eight steps
// - auto, status-read and counter-read clearing
// - six kinds of single defect insertion
module tlp_test_unit
  import tlp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic bit_stb_i,
  input wire logic frm_sync_i,
  input wire logic fas_pos_i,
  input wire logic crc_pos_i,
  input wire logic sig_frame_i,
  input wire logic line_rx_bit_i,
  input wire logic sys_tx_bit_i,
  input wire logic fbit_gen_i,
  input wire logic rx_sys_bit_i,
  input wire logic [3:0] alarm_i,
  input wire logic yellow_req_i,
  input wire logic rx_slip_i,
  input wire logic tx_slip_i,
  output logic line_tx_bit_o,
  output logic bpv_insert_o,
  output logic framer_rx_bit_o,
  output logic sys_rx_bit_o,
  output logic remote_alarm_o,
  output logic rbs_enable_o,
  output logic japan_mode_o
);
  logic [15:0] ctrl_q;
  logic [4:0] slot_q;
  logic [7:0] idle_q;
  logic sim_q;
  logic [2:0] step_q;
  logic [3:0] stat_q;
  logic [2:0] isr_q;
  logic [15:0] bec_q;
  logic [5:0] error_insert_control_q;
  logic [7:0] fec_q;
  logic [7:0] cvc_q;
  logic [7:0] crcc_q;
  logic [7:0] pos_q;
  logic jitter_attenuator_select_q;
  logic pol_q;
  logic [5:0] match_q;
  logic [7:0] hunt_q;
  logic [5:0] win_q;
  logic [6:0] werr_q;
  tlp_mon_t mon_q;
  logic [31:0] rdata;

  // apb decode
  wire acc = psel_i & penable_i;
  wire done = acc & pready_o;
  wire wr = done & pwrite_i;
  wire rd = done & ~pwrite_i;
  wire h_ctrl = (paddr_i == OFS_CTRL);
  wire h_loop = (paddr_i == OFS_LOOP);
  wire h_sim = (paddr_i == OFS_SIM);
  wire h_stat = (paddr_i == OFS_STAT);
  wire h_isr = (paddr_i == OFS_ISR);
  wire h_bec = (paddr_i == OFS_BEC);
  wire h_error_insert_control = (paddr_i == OFS_ERROR_INSERT_CONTROL);
  wire h_scnt = (paddr_i == OFS_SIMCNT);
  wire mapped = h_ctrl | h_loop | h_sim | h_stat | h_isr | h_bec | h_error_insert_control | h_scnt;

  // read data selection
  assign rdata = h_ctrl ? {16'h0000, ctrl_q} :
                 h_loop ? {16'h0000, idle_q, 3'h0, slot_q} :
                 h_sim ? {25'h0000000, step_q, 3'h0, sim_q} :
                 h_stat ? {26'h0000000, pol_q, mon_q == ST_LOCK, stat_q} :
                 h_isr ? {29'h00000000, isr_q} :
                 h_bec ? {16'h0000, bec_q} :
                 h_error_insert_control ? {26'h0000000, error_insert_control_q} :
                 h_scnt ? {8'h00, crcc_q, cvc_q, fec_q} : 32'h00000000;

  // apb answers one cycle into the access phase
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else if (ce_i) begin
      pready_o <= acc & ~pready_o;
      pslverr_o <= acc & ~pready_o & ~mapped;
      if (acc & ~pready_o) begin
        prdata_o <= rdata;
      end
    end
  end

  // frame position, bit 0 is the framing bit
  wire stb = ce_i & bit_stb_i;
  // frame sync marks the current bit, so it overrides the stored position
  wire [7:0] pos_c = frm_sync_i ? 8'h00 : pos_q;
  wire fbit = (pos_c == 8'h00);
  wire [7:0] pos_m1 = pos_c - 8'h01;
  wire [4:0] slot = pos_m1[7:3];
  wire [2:0] bis = pos_m1[2:0];
  wire slot_end = ~fbit & (bis == 3'h7);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pos_q <= 8'h00;
    end else if (stb) begin
      pos_q <= (pos_c == FRAME_LAST) ? 8'h00 : 8'(pos_c + 8'h01);
    end
  end

  // control registers; simulation trigger and defect requests
  wire sim_adv = wr & h_sim & pwdata_i[0];
  wire [2:0] step_nx = 3'(step_q + 3'h1);
  wire [5:0] error_insert_control_set = (wr & h_error_insert_control) ? pwdata_i[5:0] : 6'h00;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= CTRL_RST;
      slot_q <= SLOT_RST;
      idle_q <= IDLE_RST;
      sim_q <= 1'b0;
      step_q <= 3'h0;
    end else if (ce_i) begin
      if (wr & h_ctrl) begin
        ctrl_q <= pwdata_i[CTRL_W-1:0];
      end
      if (wr & h_loop & (pwdata_i[LP_SLOT_LSB+:5] < NUM_SLOTS)) begin
        slot_q <= pwdata_i[LP_SLOT_LSB+:5];
      end
      if (wr & h_loop) begin
        idle_q <= pwdata_i[LP_IDLE_LSB+:8];
      end
      if (wr & h_sim) begin
        sim_q <= pwdata_i[0];
      end
      if (sim_adv) begin
        step_q <= step_nx;
      end
    end
  end

  // prbs slot selection
  wire prbs_on = ctrl_q[C_PRBS_EN];
  wire prbs_slot = prbs_on & (~ctrl_q[C_FRAMED] | ~fbit);
  wire prbs_step = stb & prbs_slot;
  wire gen_bit;
  wire mon_bit;

  tlp_prbs u_gen (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .step_i(prbs_step),
    .long_i(ctrl_q[C_PRBS_LONG]),
    .load_i(1'b0),
    .din_i(1'b0),
    .bit_o(gen_bit)
  );

  // receiver input: local loop takes system data
  // local loop input
  wire frx = ctrl_q[C_LLOOP] ? sys_tx_bit_i : line_rx_bit_i;
  wire hunting = (mon_q == ST_HUNT);
  wire mon_rx = frx ^ pol_q;
  wire miss = (mon_rx != mon_bit);

  // monitor reference, seeded from line while hunting
  tlp_prbs u_mon (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .step_i(prbs_step),
    .long_i(ctrl_q[C_PRBS_LONG]),
    .load_i(hunting),
    .din_i(mon_rx),
    .bit_o(mon_bit)
  );

  wire got_lock = hunting & ~miss & (match_q == HUNT_MATCH - 6'h01);
  wire lost_lock = ~hunting & (win_q == WIN_LAST) & (7'(werr_q + {6'h00, miss}) >= LOSS_ERR);
  wire lock_chg = prbs_step & (got_lock | lost_lock);
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mon_q <= ST_HUNT;
      pol_q <= 1'b0;
      match_q <= 6'h00;
      hunt_q <= 8'h00;
      win_q <= 6'h00;
      werr_q <= 7'h00;
    end else if (prbs_step) begin
      case (mon_q)
        ST_HUNT: begin
          match_q <= miss ? 6'h00 : 6'(match_q + 6'h01);
          hunt_q <= 8'(hunt_q + 8'h01);
          win_q <= 6'h00;
          werr_q <= 7'h00;
          if (got_lock) begin
            mon_q <= ST_LOCK;
          end else if (hunt_q == HUNT_WIN) begin
            pol_q <= ~pol_q;
            match_q <= 6'h00;
          end
        end
        ST_LOCK: begin
          win_q <= 6'(win_q + 6'h01);
          werr_q <= (win_q == WIN_LAST) ? 7'h00 : 7'(werr_q + {6'h00, miss});
          match_q <= 6'h00;
          hunt_q <= 8'h00;
          if (lost_lock) begin
            mon_q <= ST_HUNT;
          end
        end
        default: begin
          mon_q <= ST_HUNT;
        end
      endcase
    end
  end

  // bit error counter, cleared by reading
  wire bec_inc = prbs_step & ~hunting & miss & ctrl_q[C_ERR_CNT_EN];
  wire bec_rd = rd & h_bec;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bec_q <= 16'h0000;
    end else if (ce_i) begin
      bec_q <= 16'((bec_rd ? 16'h0000 : bec_q) + {15'h0000, bec_inc});
    end
  end

  // insertion points for each defect kind
  wire use_fas = fbit & fas_pos_i;
  wire use_mf = fbit & ~fas_pos_i & ~crc_pos_i;
  wire use_crc = fbit & crc_pos_i;
  wire use_cas = slot_end & sig_frame_i;
  wire [5:0] used = stb ? ({1'b1, prbs_slot, use_cas, use_crc, use_mf, use_fas} & error_insert_control_q) : 6'h00;
  wire flip = used[E_FAS] | used[E_MF] | used[E_CRC] | used[E_CAS];

  // request clears after one use; new write wins
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      error_insert_control_q <= 6'h00;
    end else if (ce_i) begin
      error_insert_control_q <= (error_insert_control_q & ~used) | error_insert_control_set;
    end
  end

  // transmit route
  wire ploop = ctrl_q[C_PLOOP];
  wire chan_hit = ctrl_q[C_CHLOOP] & ~fbit & (slot == slot_q);
  wire idle_bit = idle_q[3'h7 - bis];
  // system input ignored in payload loop
  wire t_src = ploop ? ((fbit & ~ctrl_q[C_TRANSP]) ? fbit_gen_i : line_rx_bit_i) : sys_tx_bit_i;
  wire t_ch = chan_hit ? idle_bit : t_src;
  wire t_pr = prbs_slot ? (gen_bit ^ ctrl_q[C_PRBS_INV] ^ used[E_PRBS]) : t_ch;
  // line ais only on the line side
  wire t_ais = ctrl_q[C_LINE_AIS] | t_pr;
  wire t_err = t_ais ^ flip;
  // one-bit retiming stage stands for the jitter buffer
  wire t_line = ctrl_q[C_RLOOP] ? (ctrl_q[C_JITTER_ATTENUATOR_SELECT] ? jitter_attenuator_select_q : line_rx_bit_i) : t_err;
  wire r_sys = (ploop & ctrl_q[C_SYS_AIS]) ? 1'b1 : (chan_hit ? sys_tx_bit_i : rx_sys_bit_i);

  // registered line and system outputs
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      jitter_attenuator_select_q <= 1'b0;
      line_tx_bit_o <= 1'b0;
      bpv_insert_o <= 1'b0;
      framer_rx_bit_o <= 1'b0;
      sys_rx_bit_o <= 1'b0;
    end else if (ce_i) begin
      bpv_insert_o <= used[E_BPV];
      if (stb) begin
        jitter_attenuator_select_q <= line_rx_bit_i;
        line_tx_bit_o <= t_line;
        framer_rx_bit_o <= frx;
        sys_rx_bit_o <= r_sys;
      end
    end
  end

  wire [3:0] sim_alm = {step_q == STP_YEL, step_q == STP_LFA, step_q == STP_AIS, step_q == STP_LOS};
  wire sim_slip = sim_adv & (step_nx == STP_SLIP);
  wire frm_tick = stb & fbit & sim_q;
  wire fe_inc = frm_tick & (step_q == STP_FECV);
  wire crc_inc = frm_tick & (step_q == STP_CRC) & ctrl_q[C_ESF];
  wire scnt_rd = rd & h_scnt;
  wire isr_rd = rd & h_isr;
  wire [2:0] isr_set = {sim_q ? sim_slip : tx_slip_i, sim_q ? sim_slip : rx_slip_i, lock_chg};

  // automatic alarm clear, slips and counters cleared by read
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat_q <= 4'h0;
      isr_q <= 3'h0;
      fec_q <= 8'h00;
      cvc_q <= 8'h00;
      crcc_q <= 8'h00;
      remote_alarm_o <= 1'b0;
    end else if (ce_i) begin
      stat_q <= sim_q ? sim_alm : alarm_i;
      isr_q <= (isr_rd ? 3'h0 : isr_q) | isr_set;
      fec_q <= 8'((scnt_rd ? 8'h00 : fec_q) + {7'h00, fe_inc});
      cvc_q <= 8'((scnt_rd ? 8'h00 : cvc_q) + {7'h00, fe_inc});
      crcc_q <= 8'((scnt_rd ? 8'h00 : crcc_q) + {7'h00, crc_inc});
      remote_alarm_o <= yellow_req_i & ~sim_q;
    end
  end

  // plain control outputs
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rbs_enable_o <= 1'b0;
      japan_mode_o <= 1'b0;
    end else if (ce_i) begin
      rbs_enable_o <= ctrl_q[C_RBS_EN];
      japan_mode_o <= ctrl_q[C_JAPAN];
    end
  end

  // checks
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  AST_LOCK_FLAG: assert property (lock_chg |=> isr_q[I_LOCK])
    else $error("lock change not flagged");
  AST_BEC_COUNT: assert property (bec_inc & ~bec_rd |=> bec_q == 16'($past(bec_q) + 16'h0001))
    else $error("bit error not counted");
  AST_SYS_AIS: assert property (stb & ploop & ctrl_q[C_SYS_AIS] |=> sys_rx_bit_o)
    else $error("system ais missing in payload loop");
  AST_LOCAL_LOOP: assert property (stb & ctrl_q[C_LLOOP] |=> framer_rx_bit_o == $past(sys_tx_bit_i))
    else $error("local loop input wrong");
  AST_REMOTE_LOOP: assert property (stb & ctrl_q[C_RLOOP] & ~ctrl_q[C_JITTER_ATTENUATOR_SELECT]
    |=> line_tx_bit_o == $past(line_rx_bit_i))
    else $error("remote loop data wrong");
  AST_IDLE_SLOT: assert property (stb & chan_hit & ~prbs_on & ~ctrl_q[C_LINE_AIS] & ~ctrl_q[C_RLOOP] & ~flip
    |=> line_tx_bit_o == $past(idle_bit))
    else $error("idle code not sent in looped slot");
  AST_SIM_HIDE: assert property (ce_i & sim_q |=> ~remote_alarm_o)
    else $error("real alarm leaked during simulation");
  AST_STEP_ADV: assert property (ce_i & sim_adv |=> step_q == 3'($past(step_q) + 3'h1))
    else $error("simulation step not advanced");
  AST_FAS_ONCE: assert property (used[E_FAS] & ~error_insert_control_set[E_FAS] |=> ~error_insert_control_q[E_FAS] ##1 ~error_insert_control_q[E_FAS] [*2])
    else $error("defect request not cleared");
endmodule

// [shared/tlp_pkg.sv]
// constants and types of the t1 test loop and prbs unit
package tlp_pkg;
  // register byte offsets on the apb
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LOOP = 8'h04;
  localparam logic [7:0] OFS_SIM = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_ISR = 8'h10;
  localparam logic [7:0] OFS_BEC = 8'h14;
  localparam logic [7:0] OFS_ERROR_INSERT_CONTROL = 8'h18;
  localparam logic [7:0] OFS_SIMCNT = 8'h1C;
  // control register bit positions
  localparam int C_PRBS_EN = 0;
  localparam int C_PRBS_LONG = 1;
  localparam int C_PRBS_INV = 2;
  localparam int C_FRAMED = 3;
  localparam int C_ERR_CNT_EN = 4;
  localparam int C_RLOOP = 5;
  localparam int C_JITTER_ATTENUATOR_SELECT = 6;
  localparam int C_PLOOP = 7;
  localparam int C_TRANSP = 8;
  localparam int C_SYS_AIS = 9;
  localparam int C_LLOOP = 10;
  localparam int C_LINE_AIS = 11;
  localparam int C_CHLOOP = 12;
  localparam int C_RBS_EN = 13;
  localparam int C_JAPAN = 14;
  localparam int C_ESF = 15;
  localparam int CTRL_W = 16;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  // channel loop register fields
  localparam int LP_SLOT_LSB = 0;
  localparam int LP_IDLE_LSB = 8;
  localparam logic [4:0] SLOT_RST = 5'h00;
  localparam logic [7:0] IDLE_RST = 8'h00;
  // interrupt status bits
  localparam int I_LOCK = 0;
  localparam int I_RSLIP = 1;
  localparam int I_XSLIP = 2;
  // defect insertion bits
  localparam int E_FAS = 0;
  localparam int E_MF = 1;
  localparam int E_CRC = 2;
  localparam int E_CAS = 3;
  localparam int E_PRBS = 4;
  localparam int E_BPV = 5;
  // frame structure
  localparam logic [7:0] FRAME_LAST = 8'd192;
  localparam logic [4:0] NUM_SLOTS = 5'd24;
  localparam logic [3:0] ZERO_LIMIT = 4'd14;
  // prbs monitor thresholds
  localparam logic [5:0] HUNT_MATCH = 6'd32;
  localparam logic [7:0] HUNT_WIN = 8'd255;
  localparam logic [5:0] WIN_LAST = 6'd63;
  localparam logic [6:0] LOSS_ERR = 7'd24;
  // alarm simulation steps
  localparam logic [2:0] STP_LOS = 3'd1;
  localparam logic [2:0] STP_AIS = 3'd2;
  localparam logic [2:0] STP_LFA = 3'd3;
  localparam logic [2:0] STP_YEL = 3'd4;
  localparam logic [2:0] STP_SLIP = 3'd5;
  localparam logic [2:0] STP_FECV = 3'd6;
  localparam logic [2:0] STP_CRC = 3'd7;
  typedef enum logic {ST_HUNT, ST_LOCK} tlp_mon_t;
endpackage

// [rtl/tlp_prbs.sv]
// prbs shift register shared by generator and monitor
`timescale 1ns/1ps
module tlp_prbs
  import tlp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic step_i,
  input wire logic long_i,
  input wire logic load_i,
  input wire logic din_i,
  output logic bit_o
);
  logic [19:0] sr_q;
  logic [3:0] zcnt_q;
  logic raw;
  logic seen;

  // feedback taps: x^15+x^14+1 or x^20+x^17+1
  assign raw = long_i ? (sr_q[19] ^ sr_q[16]) : (sr_q[14] ^ sr_q[13]);
  // forced one after a run of zeros
  assign bit_o = (zcnt_q == ZERO_LIMIT) ? 1'b1 : raw;
  // bit that counts toward the zero run
  assign seen = load_i ? din_i : bit_o;

  // shift: self-seed from the line while loading, free-run otherwise
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sr_q <= 20'hFFFFF;
      zcnt_q <= 4'h0;
    end else if (step_i) begin
      sr_q <= {sr_q[18:0], load_i ? din_i : raw};
      zcnt_q <= seen ? 4'h0 : 4'(zcnt_q + 4'h1);
    end
  end
endmodule

// [test/tlp_far_end.sv]
// far side model: line terminal and pcm highway bit timing
`timescale 1ns/1ps
module tlp_far_end (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic loop_i,
  input wire logic line_tx_bit_i,
  output logic bit_stb_o,
  output logic frm_sync_o,
  output logic fas_pos_o,
  output logic crc_pos_o,
  output logic sig_frame_o,
  output logic line_rx_bit_o,
  output logic sys_tx_bit_o,
  output logic fbit_gen_o,
  output logic rx_sys_bit_o
);
  logic [1:0] cyc_q;
  logic [7:0] pos_q;
  logic [3:0] frm_q;
  logic [15:0] lf_q;
  logic lr_q;
  // one bit every four clocks, 193 bits a frame
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc_q <= 2'h1;
      pos_q <= 8'h0;
      frm_q <= 4'h0;
      lf_q <= 16'h1;
      lr_q <= 1'b0;
    end else begin
      cyc_q <= cyc_q + 2'h1;
      if (cyc_q == 2'h3) begin
        pos_q <= (pos_q == 8'hC0) ? 8'h0 : pos_q + 8'h1;
        frm_q <= frm_q + {3'h0, pos_q == 8'hC0};
        lf_q <= {lf_q[14:0], lf_q[15] ^ lf_q[13] ^ lf_q[12] ^ lf_q[10]};
        lr_q <= loop_i ? line_tx_bit_i : lf_q[3];
      end
    end
  end
  // line receive and system transmit data flip between bits so stale sampling shows
  assign bit_stb_o = cyc_q == 2'h0;
  assign frm_sync_o = bit_stb_o & (pos_q == 8'h0);
  assign fas_pos_o = frm_q[0];
  assign crc_pos_o = ~frm_q[0] & frm_q[1];
  assign sig_frame_o = frm_q[2:0] == 3'h5;
  assign line_rx_bit_o = lr_q ^ ~bit_stb_o;
  assign sys_tx_bit_o = lf_q[7] ^ ~bit_stb_o;
  assign fbit_gen_o = lf_q[11];
  assign rx_sys_bit_o = lf_q[9];
endmodule

// [test/tlp_test_unit_test.sv]
// bench of the t1 test loop and prbs unit
`timescale 1ns/1ps
module tlp_test_unit_test;
  import tlp_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, yreq = 1'b0, loop = 1'b0, zchk = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] alarm = 4'h0;
  logic pready, pslverr, er, stb, fsync, fas, crc, sigf, lrx, stx, fbg, rxs, ltx, bpv, frx, srx, ralm;
  int fail_count = 0, num_checks = 0, cycles = 0, zr = 0, zmax = 0, bpv_n = 0, b0 = 0;
  localparam logic [7:0] IDLE_CODE = 8'hA6;
  initial forever #5 clk_sys_i = ~clk_sys_i;
  tlp_test_unit dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .bit_stb_i(stb), .frm_sync_i(fsync), .fas_pos_i(fas),
    .crc_pos_i(crc), .sig_frame_i(sigf), .line_rx_bit_i(lrx), .sys_tx_bit_i(stx), .fbit_gen_i(fbg),
    .rx_sys_bit_i(rxs), .alarm_i(alarm), .yellow_req_i(yreq), .rx_slip_i(1'b0), .tx_slip_i(1'b0),
    .line_tx_bit_o(ltx), .bpv_insert_o(bpv), .framer_rx_bit_o(frx), .sys_rx_bit_o(srx),
    .remote_alarm_o(ralm), .rbs_enable_o(), .japan_mode_o());
  tlp_far_end far (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .loop_i(loop), .line_tx_bit_i(ltx),
    .bit_stb_o(stb), .frm_sync_o(fsync), .fas_pos_o(fas), .crc_pos_o(crc), .sig_frame_o(sigf),
    .line_rx_bit_o(lrx), .sys_tx_bit_o(stx), .fbit_gen_o(fbg), .rx_sys_bit_o(rxs));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  // cycle ceiling, zero-run length and violation pulses
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (bpv === 1'b1) bpv_n <= bpv_n + 1;
    if (stb === 1'b1 && zchk) begin
      zr = (ltx === 1'b0) ? zr + 1 : 0;
      if (zr > zmax) zmax = zr;
    end
    if (cycles == 60000) begin
      fail_count++;
      finish_test();
    end
  end
  // apb transfer: setup, access until pready, then release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    pen <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    cmp_bit("pready", 1'b1, pready);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp_word(what, e, rd & m);
  endtask
  // follow line bits and compare loop outputs of one mode
  task automatic watch(input int mode, input int nbits);
    logic l, s, f;
    int pos;
    pos = -999;
    repeat (nbits) begin
      @(posedge clk_sys_i iff stb === 1'b1);
      l = lrx;
      s = stx;
      f = fbg;
      pos = fsync ? 0 : pos + 1;
      @(posedge clk_sys_i);
      case (mode)
        0: begin
          cmp_bit("rl_line_tx", l, ltx);
          cmp_bit("rl_framer_rx", l, frx);
        end
        1: begin
          if (pos > 0) cmp_bit("ll_line_tx", s, ltx);
          cmp_bit("ll_framer_rx", s, frx);
        end
        2: begin
          cmp_bit("ais_line_tx", 1'b1, ltx);
          cmp_bit("ais_framer_rx", s, frx);
        end
        3: begin
          if (pos == 0) cmp_bit("pl_fbit", f, ltx);
          if (pos > 0) cmp_bit("pl_payload", l, ltx);
          cmp_bit("pl_sys_ais", 1'b1, srx);
        end
        4: if (pos >= 0) cmp_bit("pl_transp", l, ltx);
        default: if (pos > 184) begin
          cmp_bit("cl_idle", IDLE_CODE[192 - pos], ltx);
          cmp_bit("cl_sys_rx", s, srx);
        end
      endcase
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rdc("ctrl_reset", OFS_CTRL, 32'hFFFFFFFF, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    cmp_bit("slverr", 1'b1, er);
    cmp_word("unmapped", 32'h0, rd);
    apb(1'b1, OFS_CTRL, 32'h20);
    watch(0, 300);
    apb(1'b1, OFS_CTRL, 32'h400);
    watch(1, 400);
    apb(1'b1, OFS_CTRL, 32'hC00);
    watch(2, 100);
    apb(1'b1, OFS_CTRL, 32'h280);
    watch(3, 400);
    apb(1'b1, OFS_CTRL, 32'h180);
    watch(4, 400);
    apb(1'b1, OFS_LOOP, 32'hA617);
    apb(1'b1, OFS_LOOP, 32'hA618);
    rdc("loop_reg", OFS_LOOP, 32'hFF1F, 32'hA617);
    apb(1'b1, OFS_CTRL, 32'h1000);
    watch(5, 400);
    loop <= 1'b1;
    zchk <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h11);
    repeat (1500) @(posedge clk_sys_i);
    rdc("lock", OFS_STAT, 32'h30, 32'h10);
    rdc("lock_isr", OFS_ISR, 32'h1, 32'h1);
    apb(1'b0, OFS_BEC, 32'h0);
    apb(1'b1, OFS_ERROR_INSERT_CONTROL, 32'h10);
    repeat (400) @(posedge clk_sys_i);
    rdc("error_insert_control_prbs", OFS_ERROR_INSERT_CONTROL, 32'h3F, 32'h0);
    rdc("bec", OFS_BEC, 32'hFFFF, 32'h1);
    rdc("bec_clear", OFS_BEC, 32'hFFFF, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h3);
    repeat (4000) @(posedge clk_sys_i);
    rdc("lock_long", OFS_STAT, 32'h30, 32'h10);
    cmp_bit("zero_limit", 1'b1, zmax <= 14);
    zchk <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h5);
    repeat (4000) @(posedge clk_sys_i);
    rdc("lock_inv", OFS_STAT, 32'h30, 32'h30);
    loop <= 1'b0;
    yreq <= 1'b1;
    alarm <= 4'hE;
    apb(1'b1, OFS_CTRL, 32'h0);
    for (int k = 1; k <= 8; k++) begin
      apb(1'b1, OFS_SIM, 32'h1);
      rdc("sim_step", OFS_SIM, 32'h70, 32'(k % 8) << 4);
      if (k == 1) rdc("sim_los", OFS_STAT, 32'hF, 32'h1);
      if (k == 1) cmp_bit("remote_alarm_sim", 1'b0, ralm);
      if (k > 1 && k < 5) rdc("sim_alarm", OFS_STAT, 32'h1 << (k - 1), 32'h1 << (k - 1));
      if (k == 5) rdc("sim_slip", OFS_ISR, 32'h6, 32'h6);
      if (k == 5) rdc("slip_clear", OFS_ISR, 32'h6, 32'h0);
      if (k == 6) begin
        repeat (1600) @(posedge clk_sys_i);
        apb(1'b0, OFS_SIMCNT, 32'h0);
        cmp_bit("sim_counters", 1'b1, rd[15:0] != 16'h0);
      end
    end
    apb(1'b1, OFS_SIM, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    rdc("real_alarms", OFS_STAT, 32'hF, 32'hE);
    cmp_bit("remote_alarm", 1'b1, ralm);
    apb(1'b1, OFS_CTRL, 32'h8001);
    b0 = bpv_n;
    apb(1'b1, OFS_ERROR_INSERT_CONTROL, 32'h3F);
    repeat (8000) @(posedge clk_sys_i);
    rdc("error_insert_control_all", OFS_ERROR_INSERT_CONTROL, 32'h3F, 32'h0);
    cmp_word("bpv_pulses", 32'(b0 + 1), 32'(bpv_n));
    finish_test();
  end
endmodule
